// ===== dv/l2dr_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk_i, rst_n_i;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ram_req_o, ram_ack_i;
  logic [7:0] ram_sel_o;
  logic [l2dr_pkg::WAY_W-1:0] ram_way_o;
  logic [l2dr_pkg::IDX_W-1:0] ram_idx_o;
  logic [127:0] ram_rdata_i, rd;
  logic [15:0] ram_chk_i;
  logic [63:0] w0, w1, w2, lo;
  logic [34:0] t;
  logic [1:0] r;
  int fail_count, n_compared, cyc, reqc, i;

  l2dr_top #(.AW(8)) DUT (
    .sys_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ram_req_o, .ram_sel_o, .ram_way_o, .ram_idx_o, .ram_ack_i, .ram_rdata_i,
    .ram_chk_i
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and array request counter
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (ram_req_o) reqc <= reqc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles and closing report
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w || b) begin
      @(posedge sys_clk_i);
      if (b && s_axi_bvalid) begin
        rs = s_axi_bresp;
        b = 1'b0;
        s_axi_bready <= 1'b0;
      end
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ar, rr;
    ar = 1'b1;
    rr = 1'b1;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (ar || rr) begin
      @(posedge sys_clk_i);
      if (rr && s_axi_rvalid) begin
        d = s_axi_rdata;
        rs = s_axi_rresp;
        rr = 1'b0;
        s_axi_rready <= 1'b0;
      end
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd64(input logic [7:0] a, output logic [63:0] v);
    logic [1:0] rs;
    axi_rd(a, v[31:0], rs);
    axi_rd(a + 8'h04, v[63:32], rs);
  endtask

  // Select, way and index that a location word must put on the array port
  function automatic logic [22:0] exp_req(input logic [31:0] l);
    case (l[31:24])
      l2dr_pkg::SEL_TAG: return {l[31:24], l[20:18], 2'h0, l[15:6]};
      l2dr_pkg::SEL_DATA: return {l[31:24], l[20:18], l[15:4]};
      l2dr_pkg::SEL_VICT: return {l[31:24], 3'h0, 2'h0, l[15:6]};
      l2dr_pkg::SEL_TLB: return {l[31:24], l[20:18], 4'h0, l[7:0]};
      default: return {l[31:24], 3'h0, 7'h00, l[4:0]};
    endcase
  endfunction

  // One readout: start, answer as the array after dly cycles, fetch the three words
  task automatic run(input logic [31:0] loc, input logic sz, input logic [127:0] d,
                     input logic [15:0] ck, input int dly, input logic bad);
    logic [1:0] rs;
    logic [31:0] s;
    int q;
    q = reqc;
    axi_wr(l2dr_pkg::OFS_LOC, loc, rs);
    axi_wr(l2dr_pkg::OFS_CTRL, {30'h0000_0000, sz, 1'b1}, rs);
    if (!bad) begin
      while (!ram_req_o) @(posedge sys_clk_i);
      chk({41'h0, ram_sel_o, ram_way_o, ram_idx_o}, {41'h0, exp_req(loc)});
      if (dly > 2) begin
        // Location must not move while the array read is pending
        axi_wr(l2dr_pkg::OFS_LOC, ~loc, rs);
        axi_rd(l2dr_pkg::OFS_LOC, s, rs);
        chk({32'h0000_0000, s}, {32'h0000_0000, loc});
      end
      repeat (dly) @(posedge sys_clk_i);
      ram_ack_i <= 1'b1;
      ram_rdata_i <= d;
      ram_chk_i <= ck;
      @(posedge sys_clk_i);
      ram_ack_i <= 1'b0;
      ram_rdata_i <= ~d;
      ram_chk_i <= ~ck;
    end
    s = 32'h0000_0000;
    while (!s[l2dr_pkg::STAT_DONE]) axi_rd(l2dr_pkg::OFS_STAT, s, rs);
    chk({61'h0, s[2:0]}, {61'h0, bad, 2'b10});
    if (bad) chk(64'(reqc - q), 64'h0000_0000_0000_0000);
    rd64(l2dr_pkg::OFS_W0_LO, w0);
    rd64(l2dr_pkg::OFS_W1_LO, w1);
    rd64(l2dr_pkg::OFS_W2_LO, w2);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hF;
    {ram_ack_i, ram_rdata_i, ram_chk_i} = 145'h0;
    {fail_count, n_compared, cyc, reqc} = 128'h0;
    rst_n_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    // Bus refusals: unmapped read, write to a read-only place
    axi_rd(8'h40, w0[31:0], r);
    chk({62'h0, r}, {62'h0, l2dr_pkg::RESP_SLVERR});
    axi_wr(l2dr_pkg::OFS_STAT, 32'hFFFF_FFFF, r);
    chk({62'h0, r}, {62'h0, l2dr_pkg::RESP_SLVERR});
    $display("Test bus_refusal done");
    // Tag reads: every line state code, every way, both cache sizes
    for (i = 0; i < 8; i++) begin
      t = {27'h2D2_D2D2, {i[1:0], i[2:0]} ^ 5'h15, i[2:0]};
      rd = {93'h1FFF_FFFF_FFFF_FFFF_FFFF_FFFF, t};
      run({8'h10, 3'h7, i[2:0], 2'h3, 10'h2A5, 6'h3F}, i[0], rd, 16'hFFD3, i, 1'b0);
      if (i[0]) chk(w0, {23'h0, 7'h53, t[34:33], t[32:9], t[7:0]});
      else chk(w0, {22'h0, 7'h53, t});
      chk(w1, 64'h0000_0000_0000_0000);
      chk(w2, 64'h0000_0000_0000_0000);
    end
    $display("Test tag_read done");
    // Data read with reserved location bits set
    rd = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    run({8'h11, 3'h7, 3'h2, 2'h3, 12'hABC, 4'hF}, 1'b0, rd, 16'h5AC3, 3, 1'b0);
    chk(w0, rd[63:0]);
    chk(w1, rd[127:64]);
    chk(w2, 64'h0000_0000_0000_5AC3);
    $display("Test data_read done");
    // Victim read: way field ignored, upper raw data dropped
    run({8'h12, 8'hFF, 10'h155, 6'h3F}, 1'b0, ~rd, 16'hFFFF, 0, 1'b0);
    chk(w0, ~rd[63:0]);
    chk(w1, 64'h0000_0000_0000_0000);
    chk(w2, 64'h0000_0000_0000_0000);
    $display("Test victim_read done");
    // Second-level TLB: every memory attribute code, ways 0 to 3
    for (i = 0; i < 8; i++) begin
      lo = 64'hFFFF_FFFF_FFFF_FFFF ^ ({61'h0, i[2:0]} << 58);
      rd = {64'h0123_4567_89AB_CDBF ^ {57'h0, i[0], 6'h00}, lo};
      run({8'h18, 3'h7, 1'b0, i[1:0], 10'h3FF, 8'h5C ^ i[7:0]}, 1'b0, rd, 16'h0000, i, 1'b0);
      chk(w0, lo & 64'hDC3F_FFFF_FFFF_FFFF);
      chk(w1, rd[127:64]);
    end
    $display("Test tlb_read done");
    // Out-of-range TLB way and unknown select code are refused
    run({8'h18, 3'h0, 3'h4, 18'h0_00A5}, 1'b0, rd, 16'h0000, 0, 1'b1);
    chk(w0, 64'h0000_0000_0000_0000);
    run({8'h13, 24'h00_0040}, 1'b0, rd, 16'h0000, 0, 1'b1);
    $display("Test bad_select done");
    // First-level data TLB readout word 1
    rd = {64'h8765_4321_0FED_CBA9, 64'h0000_0000_0000_0000};
    run({8'h0A, 18'h3_FFFF, 1'b0, 5'h15}, 1'b0, rd, 16'h0000, 1, 1'b0);
    chk(w1, 64'h8765_4321_0FED_CBA9);
    $display("Test l1_tlb_read done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire

// ===== rtl/l2dr_fmt.sv
`timescale 1ns/1ns
`default_nettype none
// Lays raw array contents out into the three readout words
module l2dr_fmt (
  input wire logic [7:0] sel_i, // Select code of the read
  input wire logic size512_i, // Cache configured as 512KB
  input wire logic [127:0] raw_i, // Raw array data
  input wire logic [15:0] chk_i, // Raw check bytes
  output logic [63:0] word0_o, // Readout word 0
  output logic [63:0] word1_o, // Readout word 1
  output logic [63:0] word2_o // Readout word 2
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-type layout; undefined bits are always zero
  always_comb begin
    word0_o = '0;
    word1_o = '0;
    word2_o = '0;
    case (sel_i)
      l2dr_pkg::SEL_L1_TLB: begin
        word0_o = raw_i[l2dr_pkg::RAW_W0_HI:0] & l2dr_pkg::L1T_W0_MASK;
        word1_o = raw_i[l2dr_pkg::RAW_W1_HI:l2dr_pkg::RAW_W1_LO];
      end
      l2dr_pkg::SEL_TAG: begin
        if (size512_i) begin
          // Drop PA bit 15, everything above shifts down one
          word0_o = 64'({chk_i[l2dr_pkg::ECC_TAG_HI:0],
                         raw_i[l2dr_pkg::RT_PAGE_HW_ATTR_HI:l2dr_pkg::RT_PAGE_HW_ATTR_LO],
                         raw_i[l2dr_pkg::RT_PA_HI:l2dr_pkg::RT_PA_LO + 1],
                         raw_i[l2dr_pkg::RT_LOW_HI:0]});
        end else begin
          word0_o = 64'({chk_i[l2dr_pkg::ECC_TAG_HI:0],
                         raw_i[l2dr_pkg::RT_PAGE_HW_ATTR_HI:0]});
        end
      end
      l2dr_pkg::SEL_DATA: begin
        word0_o = raw_i[l2dr_pkg::RAW_W0_HI:0];
        word1_o = raw_i[l2dr_pkg::RAW_W1_HI:l2dr_pkg::RAW_W1_LO];
        word2_o = 64'(chk_i);
      end
      l2dr_pkg::SEL_VICT: begin
        word0_o = raw_i[l2dr_pkg::RAW_W0_HI:0];
      end
      l2dr_pkg::SEL_TLB: begin
        word0_o = raw_i[l2dr_pkg::RAW_W0_HI:0] & l2dr_pkg::TLB_W0_MASK;
        word1_o = raw_i[l2dr_pkg::RAW_W1_HI:l2dr_pkg::RAW_W1_LO];
      end
      default: begin
        word0_o = '0;
      end
    endcase
  end

endmodule // l2dr_fmt
`default_nettype wire

// ===== rtl/l2dr_pkg.sv
package l2dr_pkg;

  // Select codes carried in the location word
  localparam logic [7:0] SEL_L1_TLB = 8'h0A;
  localparam logic [7:0] SEL_TAG = 8'h10;
  localparam logic [7:0] SEL_DATA = 8'h11;
  localparam logic [7:0] SEL_VICT = 8'h12;
  localparam logic [7:0] SEL_TLB = 8'h18;

  // Location word field positions
  localparam int LOC_SEL_HI = 31;
  localparam int LOC_SEL_LO = 24;
  localparam int LOC_WAY_HI = 20;
  localparam int LOC_WAY_LO = 18;
  localparam int LOC_IDX_HI = 15;
  localparam int LOC_TAG_IDX_LO = 6;
  localparam int LOC_DAT_IDX_LO = 4;
  localparam int LOC_TLB_IDX_HI = 7;
  localparam int LOC_L1T_IDX_HI = 4;
  localparam int TLB_WAY_TOP = 2;
  localparam int IDX_W = 12;
  localparam int WAY_W = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_LOC = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_W0_LO = 8'h10;
  localparam logic [7:0] OFS_W0_HI = 8'h14;
  localparam logic [7:0] OFS_W1_LO = 8'h18;
  localparam logic [7:0] OFS_W1_HI = 8'h1C;
  localparam logic [7:0] OFS_W2_LO = 8'h20;
  localparam logic [7:0] OFS_W2_HI = 8'h24;

  // Control and status bits
  localparam int CTRL_GO = 0;
  localparam int CTRL_SIZE512 = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_BAD = 2;
  localparam logic [31:0] LOC_RESET = 32'h0000_0000;
  localparam logic CTRL_SIZE512_RESET = 1'b0;

  // Raw tag entry layout as the array delivers it
  localparam int RT_LOW_HI = 7;
  localparam int RT_PA_LO = 8;
  localparam int RT_PA_HI = 32;
  localparam int RT_PAGE_HW_ATTR_LO = 33;
  localparam int RT_PAGE_HW_ATTR_HI = 34;
  localparam int ECC_TAG_HI = 6;
  localparam int RAW_W0_HI = 63;
  localparam int RAW_W1_LO = 64;
  localparam int RAW_W1_HI = 127;

  // Masks leaving only defined bits of TLB data words
  localparam logic [63:0] TLB_W0_MASK = 64'hDC3F_FFFF_FFFF_FFFF;
  localparam logic [63:0] L1T_W0_MASK = 64'hC61C_007F_FFFF_FFFF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== rtl/l2dr_top.sv
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - L1 TLB word1: attr bit, PA, VA
// - Code 0x10 selects tag: way, index 15:6
// - Code 0x11 selects data: way, index 15:4
// - Code 0x12 selects victim, index only
// - 256KB tag word0 layout, top zero
// - 512KB tag word0 layout, top zero
// - Tag low flags: ns, vindex, share, l1valid
// - Line state code passes unchanged
// - Tag read leaves words 1,2 zero
// - Data read: low then high half
// - Data word2 holds two check bytes
// - Victim word0 packs replacement fields
// - Victim read leaves words 1,2 zero
// - Code 0x18 selects TLB, ways 0-3
// - TLB word0 share bits, reserved zero
// - TLB memory attribute field passes through
// - Coalesced flag bit 6 passes through
module l2dr_top #(
  parameter int AW = 8 // AXI address width
) (
  input wire logic sys_clk_i, // Core clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic ram_req_o, // Array read request
  output logic [7:0] ram_sel_o, // Array select code
  output logic [l2dr_pkg::WAY_W-1:0] ram_way_o, // Array way
  output logic [l2dr_pkg::IDX_W-1:0] ram_idx_o, // Array index
  input wire logic ram_ack_i, // Array data valid
  input wire logic [127:0] ram_rdata_i, // Array raw data
  input wire logic [15:0] ram_chk_i // Array raw check bytes
);

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_CAPT} l2dr_state_e;

  logic [31:0] loc_ff;
  logic size512_ff;
  logic done_ff;
  logic bad_ff;
  l2dr_state_e state_ff;
  logic [7:0] sel_ff;
  logic [l2dr_pkg::WAY_W-1:0] way_ff;
  logic [l2dr_pkg::IDX_W-1:0] idx_ff;
  logic [63:0] word0_ff;
  logic [63:0] word1_ff;
  logic [63:0] word2_ff;
  logic [63:0] fmt_w0;
  logic [63:0] fmt_w1;
  logic [63:0] fmt_w2;
  logic aw_held_ff;
  logic w_held_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_fire;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic go;
  logic [7:0] loc_sel;
  logic [l2dr_pkg::WAY_W-1:0] loc_way;
  logic loc_ok;
  logic [l2dr_pkg::IDX_W-1:0] loc_idx;
  logic [31:0] rd_mux;
  logic rd_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
  assign wr_fire = (aw_held_ff || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held_ff || (s_axi_wvalid && s_axi_wready));

  // Hold whichever half arrived first
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // Write response; unmapped or read-only words answer with an error
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= l2dr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_addr == l2dr_pkg::OFS_LOC || wr_addr == l2dr_pkg::OFS_CTRL) ?
                     l2dr_pkg::RESP_OKAY : l2dr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Location and control registers; location locked while a read runs
  assign go = wr_fire && wr_addr == l2dr_pkg::OFS_CTRL && wr_strb[0] &&
              wr_data[l2dr_pkg::CTRL_GO] && state_ff == ST_IDLE;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loc_ff <= l2dr_pkg::LOC_RESET;
      size512_ff <= l2dr_pkg::CTRL_SIZE512_RESET;
    end else if (wr_fire && state_ff == ST_IDLE) begin
      if (wr_addr == l2dr_pkg::OFS_LOC) begin
        for (int b = 0; b < 4; b++) begin
          if (wr_strb[b]) begin
            loc_ff[b*8 +: 8] <= wr_data[b*8 +: 8];
          end
        end
      end
      if (wr_addr == l2dr_pkg::OFS_CTRL && wr_strb[0]) begin
        size512_ff <= wr_data[l2dr_pkg::CTRL_SIZE512];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode the location word; reserved bits never reach the array
  assign loc_sel = loc_ff[l2dr_pkg::LOC_SEL_HI:l2dr_pkg::LOC_SEL_LO];
  assign loc_way = loc_ff[l2dr_pkg::LOC_WAY_HI:l2dr_pkg::LOC_WAY_LO];

  always_comb begin
    loc_ok = 1'b1;
    loc_idx = '0;
    case (loc_sel)
      l2dr_pkg::SEL_TAG: begin
        loc_idx = IDX_W_T'(loc_ff[l2dr_pkg::LOC_IDX_HI:l2dr_pkg::LOC_TAG_IDX_LO]);
      end
      l2dr_pkg::SEL_DATA: begin
        loc_idx = loc_ff[l2dr_pkg::LOC_IDX_HI:l2dr_pkg::LOC_DAT_IDX_LO];
      end
      l2dr_pkg::SEL_VICT: begin
        loc_idx = IDX_W_T'(loc_ff[l2dr_pkg::LOC_IDX_HI:l2dr_pkg::LOC_TAG_IDX_LO]);
      end
      l2dr_pkg::SEL_TLB: begin
        loc_idx = IDX_W_T'(loc_ff[l2dr_pkg::LOC_TLB_IDX_HI:0]);
        loc_ok = !loc_way[l2dr_pkg::TLB_WAY_TOP];
      end
      l2dr_pkg::SEL_L1_TLB: begin
        loc_idx = IDX_W_T'(loc_ff[l2dr_pkg::LOC_L1T_IDX_HI:0]);
      end
      default: begin
        loc_ok = 1'b0;
      end
    endcase
  end

  localparam int IDX_W_T = l2dr_pkg::IDX_W;

  //////////////////////////////////////////////////////////////////////////////
  // Read sequencer: request until the array acknowledges, then capture
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      sel_ff <= '0;
      way_ff <= '0;
      idx_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (go && loc_ok) begin
            state_ff <= ST_REQ;
            sel_ff <= loc_sel;
            way_ff <= (loc_sel == l2dr_pkg::SEL_VICT ||
                       loc_sel == l2dr_pkg::SEL_L1_TLB) ? '0 : loc_way;
            idx_ff <= loc_idx;
          end
        end
        ST_REQ: begin
          if (ram_ack_i) begin
            state_ff <= ST_CAPT;
          end
        end
        ST_CAPT: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign ram_req_o = state_ff == ST_REQ;
  assign ram_sel_o = sel_ff;
  assign ram_way_o = way_ff;
  assign ram_idx_o = idx_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Readout formatting and capture
  l2dr_fmt u_fmt (
    .sel_i(sel_ff),
    .size512_i(size512_ff),
    .raw_i(ram_rdata_i),
    .chk_i(ram_chk_i),
    .word0_o(fmt_w0),
    .word1_o(fmt_w1),
    .word2_o(fmt_w2)
  );

  // Words load on acknowledge; a refused start clears them
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word0_ff <= '0;
      word1_ff <= '0;
      word2_ff <= '0;
    end else if (ram_req_o && ram_ack_i) begin
      word0_ff <= fmt_w0;
      word1_ff <= fmt_w1;
      word2_ff <= fmt_w2;
    end else if (go && !loc_ok) begin
      word0_ff <= '0;
      word1_ff <= '0;
      word2_ff <= '0;
    end
  end

  // Status flags: a start clears done and bad, a refused start sets both
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else if (go) begin
      done_ff <= !loc_ok;
      bad_ff <= !loc_ok;
    end else if (state_ff == ST_CAPT) begin
      done_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      l2dr_pkg::OFS_LOC: rd_mux = loc_ff;
      l2dr_pkg::OFS_CTRL: rd_mux = 32'(size512_ff) << l2dr_pkg::CTRL_SIZE512;
      l2dr_pkg::OFS_STAT: rd_mux = 32'({bad_ff, done_ff, state_ff != ST_IDLE});
      l2dr_pkg::OFS_W0_LO: rd_mux = word0_ff[31:0];
      l2dr_pkg::OFS_W0_HI: rd_mux = word0_ff[63:32];
      l2dr_pkg::OFS_W1_LO: rd_mux = word1_ff[31:0];
      l2dr_pkg::OFS_W1_HI: rd_mux = word1_ff[63:32];
      l2dr_pkg::OFS_W2_LO: rd_mux = word2_ff[31:0];
      l2dr_pkg::OFS_W2_HI: rd_mux = word2_ff[63:32];
      default: begin
        rd_mux = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Data registered one cycle after the address is taken
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= l2dr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? l2dr_pkg::RESP_OKAY : l2dr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_tag_addr;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_ff == ST_IDLE && go && loc_sel == l2dr_pkg::SEL_TAG) |=>
      ram_req_o && ram_way_o == $past(loc_way) &&
      ram_idx_o == IDX_W_T'($past(loc_ff[l2dr_pkg::LOC_IDX_HI:l2dr_pkg::LOC_TAG_IDX_LO]));
  endproperty
  a_tag_addr: assert property (p_tag_addr) else $error("tag way or index wrong");

  property p_data_addr;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (go && loc_sel == l2dr_pkg::SEL_DATA) |=>
      ram_idx_o == $past(loc_ff[l2dr_pkg::LOC_IDX_HI:l2dr_pkg::LOC_DAT_IDX_LO]);
  endproperty
  a_data_addr: assert property (p_data_addr) else $error("data index wrong");

  property p_vict_way;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ram_req_o && ram_sel_o == l2dr_pkg::SEL_VICT) |-> ram_way_o == '0;
  endproperty
  a_vict_way: assert property (p_vict_way) else $error("victim read carries a way");

  property p_tlb_way;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (go && loc_sel == l2dr_pkg::SEL_TLB && loc_way[l2dr_pkg::TLB_WAY_TOP]) |=>
      !ram_req_o [*2] ##0 bad_ff;
  endproperty
  a_tlb_way: assert property (p_tlb_way) else $error("bad TLB way not refused");

  property p_tag_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ram_req_o && ram_ack_i && ram_sel_o == l2dr_pkg::SEL_TAG) |=>
      word1_ff == '0 && word2_ff == '0 && word0_ff[63:42] == '0;
  endproperty
  a_tag_zero: assert property (p_tag_zero) else $error("tag readout not zero");

  property p_vict_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ram_req_o && ram_ack_i && ram_sel_o == l2dr_pkg::SEL_VICT) |=>
      word1_ff == '0 && word2_ff == '0 && word0_ff == $past(ram_rdata_i[63:0]);
  endproperty
  a_vict_zero: assert property (p_vict_zero) else $error("victim readout wrong");

  property p_data_chk;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ram_req_o && ram_ack_i && ram_sel_o == l2dr_pkg::SEL_DATA) |=>
      word2_ff[15:0] == $past(ram_chk_i) && word2_ff[63:16] == '0 &&
      word1_ff == $past(ram_rdata_i[127:64]);
  endproperty
  a_data_chk: assert property (p_data_chk) else $error("data readout wrong");

  property p_tlb_res;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (ram_req_o && ram_ack_i && ram_sel_o == l2dr_pkg::SEL_TLB) |=>
      !word0_ff[61] && word0_ff[57:54] == '0 && word0_ff[63:62] == $past(ram_rdata_i[63:62]);
  endproperty
  a_tlb_res: assert property (p_tlb_res) else $error("TLB reserved bits set");

endmodule // l2dr_top
`default_nettype wire
